// ===== common/fbp_map.svh
// register offsets, field positions, reset values and sizes of the protect decode
// assumes a 32-bit word-aligned register window
`ifndef FBP_MAP_SVH
`define FBP_MAP_SVH

`define FBP_ADDR_W        8
`define FBP_SEC_W         9
`define FBP_CNT_W         16

`define FBP_OFF_CTRL      8'h00
`define FBP_OFF_RANGE     8'h04
`define FBP_OFF_CMD       8'h08
`define FBP_OFF_RESULT    8'h0c

`define FBP_HSIZE_WORD    3'h2
`define FBP_HRESP_OKAY    1'b0

`define FBP_CTRL_TBS      0
`define FBP_CTRL_LVL_LO   1
`define FBP_CTRL_LVL_HI   4
`define FBP_CTRL_VAR_LO   8
`define FBP_CTRL_VAR_HI   9

`define FBP_RNG_FIRST_LO  0
`define FBP_RNG_FIRST_HI  8
`define FBP_RNG_LAST_LO   16
`define FBP_RNG_LAST_HI   24
`define FBP_RNG_NONE      28
`define FBP_RNG_ALL       29

`define FBP_CMD_SEC_LO    0
`define FBP_CMD_SEC_HI    8
`define FBP_CMD_ERASE     16

`define FBP_RES_REJ       0
`define FBP_RES_ACC       1
`define FBP_RES_BUSY      2
`define FBP_RES_CNT_LO    16
`define FBP_RES_CNT_HI    31

`define FBP_VAR_128       2'h0
`define FBP_VAR_256       2'h1
`define FBP_VAR_512       2'h2
`define FBP_LVL_BASE      4'h7
`define FBP_RST_VAR       2'h0
`define FBP_RST_LVL       4'h0
`define FBP_RST_TBS       1'b0

`endif

// ===== common/fbp_pkg.sv
// types shared by the protect decode, its bus slave and its top
// assumes fbp_map.svh for the sector and address widths
`include "fbp_map.svh"

package fbp_pkg;

  typedef struct packed {
    logic [1:0] variant;
    logic [3:0] level;
    logic       tbs;
  } fbp_ctrl_t;

  typedef struct packed {
    logic                  none;
    logic                  all;
    logic [`FBP_SEC_W-1:0] first;
    logic [`FBP_SEC_W-1:0] last;
  } fbp_range_t;

  typedef struct packed {
    logic                   wr;
    logic [`FBP_ADDR_W-1:0] addr;
    logic [31:0]            data;
  } fbp_wreq_t;

  typedef enum logic [1:0] {
    FBP_IDLE  = 2'h0,
    FBP_ISSUE = 2'h1
  } fbp_state_t;

endpackage : fbp_pkg

// ===== rtl/fbp_ahb_slave.sv
// AHB-Lite slave front end: zero wait states, OKAY only, whole-word transfers
// assumes a single master; reads sample register contents in the address phase
`timescale 1ns/1ps
`default_nettype none
`include "fbp_map.svh"

module fbp_ahb_slave (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  output fbp_pkg::fbp_wreq_t          wreq,
  output logic [`FBP_ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]            rd_data
);

  typedef struct packed {
    logic                   wr_pend;
    logic [`FBP_ADDR_W-1:0] wr_addr;
    logic [31:0]            rdata;
  } fbp_ahb_st_t;

  fbp_ahb_st_t st_r;
  fbp_ahb_st_t st_nxt;
  logic        take;

  assign take      = hsel && htrans[1] && hready && (hsize == `FBP_HSIZE_WORD);
  assign rd_addr   = haddr[`FBP_ADDR_W-1:0];
  assign hreadyout = 1'b1;
  assign hresp     = `FBP_HRESP_OKAY;
  assign hrdata    = st_r.rdata;
  assign wreq.wr   = st_r.wr_pend;
  assign wreq.addr = st_r.wr_addr;
  assign wreq.data = hwdata;

  always_comb begin
    st_nxt = st_r;
    if (hready) begin
      st_nxt.wr_pend = take && hwrite;
      st_nxt.wr_addr = haddr[`FBP_ADDR_W-1:0];
      if (take && !hwrite) begin
        st_nxt.rdata = rd_data;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : fbp_ahb_slave
`default_nettype wire

// ===== rtl/fbp_prot_decode.sv
// maps variant, top/bottom select and protect level onto a protected sector range
// assumes inputs settled from registers; purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "fbp_map.svh"

module fbp_prot_decode (
  input  wire logic [1:0]       variant,
  input  wire logic             top_bottom_select,
  input  wire logic [3:0]       protect_level,
  output fbp_pkg::fbp_range_t   range
);

  logic [3:0]            max_lvl;
  logic [`FBP_SEC_W:0]   nsec;
  logic [`FBP_SEC_W:0]   cnt;

  always_comb begin
    // 128, 256, 512 sectors have 7, 8, 9 growing levels; code 3 acts as 512
    max_lvl = (variant == 2'h3) ? `FBP_LVL_BASE + 4'h2 : `FBP_LVL_BASE + {2'h0, variant};
    nsec    = (`FBP_SEC_W+1)'(1) << max_lvl;
    cnt     = '0;
    range   = '0;
    if (protect_level == 4'h0) begin
      range.none = 1'b1;
    end else if (protect_level > max_lvl) begin
      range.all   = 1'b1;
      range.first = '0;
      range.last  = `FBP_SEC_W'(nsec - 1'b1);
    end else begin
      cnt = (`FBP_SEC_W+1)'(1) << (protect_level - 4'h1);
      if (top_bottom_select) begin
        range.first = '0;
        range.last  = `FBP_SEC_W'(cnt - 1'b1);
      end else begin
        range.first = `FBP_SEC_W'(nsec - cnt);
        range.last  = `FBP_SEC_W'(nsec - 1'b1);
      end
    end
  end

endmodule : fbp_prot_decode
`default_nettype wire

// ===== rtl/fbp_protect_top.sv
// block protection decode and program/erase gate for a serial flash array
// assumes an AHB-Lite master for the registers and an array engine with req/ack
//
// How it works
// - 128 bottom: level n protects 0..2^(n-1)-1
// - 128 bottom: levels 8-15 protect everything
// - 256 top: level n protects top 2^(n-1)
// - 256 top: levels 9-15 protect everything
// - 256 bottom: level n protects 0..2^(n-1)-1
// - 256 bottom: levels 9-15 protect everything
// - 512 top: level n protects top 2^(n-1)
// - 512 top: levels 10-15 protect everything
// - 128 top: top 2^(n-1), levels 8-15 all
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fbp_map.svh"

module fbp_protect_top (
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  output logic                       arr_req,
  output logic [`FBP_SEC_W-1:0]      arr_sector,
  output logic                       arr_erase,
  input  wire logic                  arr_ack
);

  typedef struct packed {
    fbp_pkg::fbp_ctrl_t    ctrl;
    fbp_pkg::fbp_range_t   range;
    logic [`FBP_SEC_W-1:0] sector;
    logic                  erase;
    fbp_pkg::fbp_state_t   fsm;
    logic                  last_rej;
    logic                  last_acc;
    logic [`FBP_CNT_W-1:0] rej_cnt;
  } fbp_top_st_t;

  logic                   rst_meta_r;
  logic                   rst_n;
  fbp_top_st_t            st_r;
  fbp_top_st_t            st_nxt;
  fbp_pkg::fbp_wreq_t     wreq;
  fbp_pkg::fbp_range_t    dec_range;
  logic [`FBP_ADDR_W-1:0] rd_addr;
  logic [31:0]            rd_data;
  logic [`FBP_SEC_W-1:0]  wr_sec;
  logic                   wr_hit;

  //////////////////////////////////////////////////////////////////////////////
  // reset release

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus and decode

  fbp_ahb_slave u_bus (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wreq      (wreq),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data)
  );

  fbp_prot_decode u_dec (
    .variant           (st_r.ctrl.variant),
    .top_bottom_select (st_r.ctrl.tbs),
    .protect_level     (st_r.ctrl.level),
    .range             (dec_range)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register reads

  always_comb begin
    rd_data = '0;
    unique case (rd_addr)
      `FBP_OFF_CTRL: begin
        rd_data[`FBP_CTRL_TBS]                     = st_r.ctrl.tbs;
        rd_data[`FBP_CTRL_LVL_HI:`FBP_CTRL_LVL_LO] = st_r.ctrl.level;
        rd_data[`FBP_CTRL_VAR_HI:`FBP_CTRL_VAR_LO] = st_r.ctrl.variant;
      end
      `FBP_OFF_RANGE: begin
        rd_data[`FBP_RNG_FIRST_HI:`FBP_RNG_FIRST_LO] = st_r.range.first;
        rd_data[`FBP_RNG_LAST_HI:`FBP_RNG_LAST_LO]   = st_r.range.last;
        rd_data[`FBP_RNG_NONE]                       = st_r.range.none;
        rd_data[`FBP_RNG_ALL]                        = st_r.range.all;
      end
      `FBP_OFF_CMD: begin
        rd_data[`FBP_CMD_SEC_HI:`FBP_CMD_SEC_LO] = st_r.sector;
        rd_data[`FBP_CMD_ERASE]                  = st_r.erase;
      end
      `FBP_OFF_RESULT: begin
        rd_data[`FBP_RES_REJ]                    = st_r.last_rej;
        rd_data[`FBP_RES_ACC]                    = st_r.last_acc;
        rd_data[`FBP_RES_BUSY]                   = (st_r.fsm == fbp_pkg::FBP_ISSUE);
        rd_data[`FBP_RES_CNT_HI:`FBP_RES_CNT_LO] = st_r.rej_cnt;
      end
      default: rd_data = '0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // protection check and command gate

  assign wr_sec = wreq.data[`FBP_CMD_SEC_HI:`FBP_CMD_SEC_LO];
  // the decoded range is refused, or every sector when all is set; otherwise sectors past the array end go to the engine
  assign wr_hit = st_r.range.all
                  || (!st_r.range.none && wr_sec >= st_r.range.first && wr_sec <= st_r.range.last);

  always_comb begin
    st_nxt       = st_r;
    st_nxt.range = dec_range;
    if (wreq.wr && wreq.addr == `FBP_OFF_CTRL) begin
      st_nxt.ctrl.tbs     = wreq.data[`FBP_CTRL_TBS];
      st_nxt.ctrl.level   = wreq.data[`FBP_CTRL_LVL_HI:`FBP_CTRL_LVL_LO];
      st_nxt.ctrl.variant = wreq.data[`FBP_CTRL_VAR_HI:`FBP_CTRL_VAR_LO];
    end
    unique case (st_r.fsm)
      fbp_pkg::FBP_IDLE: begin
        if (wreq.wr && wreq.addr == `FBP_OFF_CMD) begin
          st_nxt.sector = wr_sec;
          st_nxt.erase  = wreq.data[`FBP_CMD_ERASE];
          if (wr_hit) begin
            st_nxt.last_rej = 1'b1;
            st_nxt.last_acc = 1'b0;
            if (st_r.rej_cnt != '1) begin
              st_nxt.rej_cnt = st_r.rej_cnt + 1'b1;
            end
          end else begin
            st_nxt.last_rej = 1'b0;
            st_nxt.last_acc = 1'b1;
            st_nxt.fsm      = fbp_pkg::FBP_ISSUE;
          end
        end
      end
      fbp_pkg::FBP_ISSUE: begin
        if (arr_ack) begin
          st_nxt.fsm = fbp_pkg::FBP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r              <= '0;
      st_r.ctrl.tbs     <= `FBP_RST_TBS;
      st_r.ctrl.level   <= `FBP_RST_LVL;
      st_r.ctrl.variant <= `FBP_RST_VAR;
      st_r.range.none   <= 1'b1;
      st_r.fsm          <= fbp_pkg::FBP_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign arr_req    = (st_r.fsm == fbp_pkg::FBP_ISSUE);
  assign arr_sector = st_r.sector;
  assign arr_erase  = st_r.erase;

endmodule : fbp_protect_top
`default_nettype wire

// ===== sim/fbp_array_model.sv
// array engine model: raises ack dly+1 cycles after each request rises
// assumes req holds until ack is sampled
`timescale 1ns/1ps
`default_nettype none
module fbp_array_model (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       arr_req,
  input  wire logic [8:0] arr_sector,
  input  wire logic       arr_erase,
  input  wire logic [3:0] dly,
  output logic            arr_ack,
  output logic [8:0]      last_sec,
  output logic            last_ers,
  output logic [7:0]      n_done
);
  logic [3:0] wait_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      arr_ack  <= 1'b0;
      wait_r   <= 4'h0;
      last_sec <= 9'h000;
      last_ers <= 1'b0;
      n_done   <= 8'h00;
    end else if (arr_req && !arr_ack && wait_r >= dly) begin
      arr_ack  <= 1'b1;
      wait_r   <= 4'h0;
      last_sec <= arr_sector;
      last_ers <= arr_erase;
      n_done   <= n_done + 8'h01;
    end else begin
      arr_ack <= 1'b0;
      if (arr_req && !arr_ack) wait_r <= wait_r + 4'h1;
    end
  end
endmodule : fbp_array_model
`default_nettype wire

// ===== sim/fbp_protect_props.sv
// port assertions for the protect block
// assumes a bind onto fbp_protect_top, single clock
`timescale 1ns/1ps
`default_nettype none
`include "fbp_map.svh"
module fbp_protect_props (
  input wire logic                  clk_sys,
  input wire logic                  nrst,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [2:0]            hsize,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic [31:0]           hrdata,
  input wire logic                  arr_req,
  input wire logic [`FBP_SEC_W-1:0] arr_sector,
  input wire logic                  arr_erase,
  input wire logic                  arr_ack
);
  wire logic take = hsel && htrans[1] && hready && hsize == `FBP_HSIZE_WORD;
  wire logic cmd_take = take && hwrite && haddr[7:0] == `FBP_OFF_CMD;
  wire logic rng_rd = take && !hwrite && haddr[7:0] == `FBP_OFF_RANGE;
  logic       wr_ctrl_r;
  logic       fresh_r;
  logic [9:0] ctrl_r;
  // shadow of the control word; range is stale for one edge after a write
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ctrl_r <= 1'b0;
      fresh_r   <= 1'b0;
      ctrl_r    <= 10'h000;
    end else begin
      wr_ctrl_r <= take && hwrite && haddr[7:0] == `FBP_OFF_CTRL;
      fresh_r   <= wr_ctrl_r;
      if (wr_ctrl_r) ctrl_r <= hwdata[9:0];
    end
  end
  wire logic [3:0] lvl = ctrl_r[4:1];
  wire logic [3:0] lim = (ctrl_r[9:8] == 2'h0) ? 4'h7 : (ctrl_r[9:8] == 2'h1) ? 4'h8 : 4'h9;
  wire logic [8:0] smax = (ctrl_r[9:8] == 2'h0) ? 9'h07f : (ctrl_r[9:8] == 2'h1) ? 9'h0ff : 9'h1ff;
  wire logic [8:0] cnt = 9'h001 << (lvl - 4'h1);
  wire logic rd_ok = rng_rd && !fresh_r;
  wire logic part = rd_ok && lvl != 4'h0 && lvl <= lim;
  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_wait; arr_req && !arr_ack; endsequence
  sequence s_done; arr_req && arr_ack; endsequence
  a_bus_okay: assert property (hresp == `FBP_HRESP_OKAY && hreadyout)
    else $error("bus answer not okay");
  a_req_holds: assert property (s_wait |=> arr_req && $stable(arr_sector) && $stable(arr_erase))
    else $error("request changed before ack");
  a_req_drops: assert property (s_done |=> !arr_req)
    else $error("request held after ack");
  a_req_cause: assert property ($rose(arr_req) |-> $past(cmd_take, 2))
    else $error("request without command write");
  a_req_data: assert property ($rose(arr_req) |->
    arr_sector == $past(hwdata[8:0]) && arr_erase == $past(hwdata[16]))
    else $error("request carries wrong sector");
  a_level_none: assert property (rd_ok && lvl == 4'h0 |=> hrdata[29:28] == 2'h1)
    else $error("level zero not unprotected");
  a_over_all: assert property (rd_ok && lvl > lim |=> hrdata[29:28] == 2'h2)
    else $error("high level not fully protected");
  a_top_range: assert property (part && !ctrl_r[0] |=>
    hrdata[24:16] == smax && hrdata[8:0] == smax - cnt + 9'h1)
    else $error("top range wrong");
  a_bot_range: assert property (part && ctrl_r[0] |=>
    hrdata[8:0] == 9'h000 && hrdata[24:16] == cnt - 9'h1)
    else $error("bottom range wrong");
endmodule : fbp_protect_props
bind fbp_protect_top fbp_protect_props u_props (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .arr_req(arr_req), .arr_sector(arr_sector), .arr_erase(arr_erase),
  .arr_ack(arr_ack));
`default_nettype wire

// ===== sim/test_flash_block_protect_decode.sv
// self-checking bench for the protect block
// assumes zero-wait bus slave and the array engine model
`timescale 1ns/1ps
`default_nettype none
`include "fbp_map.svh"
module test_flash_block_protect_decode;
  logic clk_sys = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = `FBP_HSIZE_WORD;
  logic [3:0] dly = 4'h0;
  logic hreadyout, hresp, arr_req, arr_erase, arr_ack, last_ers;
  logic [8:0] arr_sector, last_sec;
  logic [7:0] n_done;
  int miscompares = 0, num_checks = 0, cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  fbp_protect_top dut (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .arr_req(arr_req), .arr_sector(arr_sector), .arr_erase(arr_erase), .arr_ack(arr_ack));
  fbp_array_model engine (.clk_sys(clk_sys), .nrst(nrst), .arr_req(arr_req), .arr_sector(arr_sector),
    .arr_erase(arr_erase), .dly(dly), .arr_ack(arr_ack), .last_sec(last_sec), .last_ers(last_ers), .n_done(n_done));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic wait_idle;
    int n = 0;
    do begin
      ahb(1'b0, `FBP_OFF_RESULT, 32'h0);
      n++;
    end while (rd[2] !== 1'b0 && n < 40);
    check("busy", rd & 32'h4, 32'h0);
  endtask : wait_idle
  task automatic t_reset;
    ahb(1'b0, `FBP_OFF_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    ahb(1'b1, `FBP_OFF_RANGE, 32'hffff_ffff);
    ahb(1'b0, `FBP_OFF_RANGE, 32'h0);
    check("range reset", rd & 32'h3000_0000, 32'h1000_0000);
    ahb(1'b1, 8'h10, 32'hffff_ffff);
    ahb(1'b0, 8'h10, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_decode;
    logic [31:0] exp;
    int s, c;
    for (int v = 0; v < 3; v++)
      for (int t = 0; t < 2; t++)
        for (int l = 0; l < 16; l++) begin
          ahb(1'b1, `FBP_OFF_CTRL, (v << 8) | (l << 1) | t);
          ahb(1'b0, `FBP_OFF_RANGE, 32'h0);
          s = 128 << v;
          c = (l == 0) ? 0 : 1 << (l - 1);
          if (l == 0 || l > 7 + v) begin
            exp = (l == 0) ? 32'h1000_0000 : 32'h2000_0000;
            check("range ends", rd & 32'h3000_0000, exp);
          end else begin
            exp = t ? (c - 1) << 16 : ((s - 1) << 16) | (s - c);
            check("range", rd & 32'h31ff_01ff, exp);
          end
        end
    // variant code 3 decodes as the 512-sector array
    ahb(1'b1, `FBP_OFF_CTRL, 32'h312);
    ahb(1'b0, `FBP_OFF_RANGE, 32'h0);
    check("range code 3", rd & 32'h31ff_01ff, 32'h01ff_0100);
    $display("test decode done");
  endtask : t_decode
  task automatic t_gate;
    ahb(1'b1, `FBP_OFF_CTRL, 32'h7);
    ahb(1'b1, `FBP_OFF_CMD, 32'h0001_0003);
    ahb(1'b0, `FBP_OFF_RESULT, 32'h0);
    check("reject", rd & 32'hffff_0003, 32'h0001_0001);
    dly <= 4'h6;
    ahb(1'b1, `FBP_OFF_CMD, 32'h0001_0004);
    ahb(1'b1, `FBP_OFF_CMD, 32'h0000_0005);
    wait_idle();
    check("erase", {last_ers, last_sec, n_done}, {1'b1, 9'h004, 8'h01});
    check("accept", rd & 32'hffff_0003, 32'h0001_0002);
    dly <= 4'h0;
    ahb(1'b1, `FBP_OFF_CTRL, 32'h102);
    ahb(1'b1, `FBP_OFF_CMD, 32'h0ff);
    ahb(1'b1, `FBP_OFF_CMD, 32'h0fe);
    wait_idle();
    check("program", {last_ers, last_sec, n_done}, {1'b0, 9'h0fe, 8'h02});
    check("count", rd & 32'hffff_0000, 32'h0002_0000);
    $display("test gate done");
  endtask : t_gate
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_decode();
    t_gate();
    give_verdict();
  end
endmodule : test_flash_block_protect_decode
`default_nettype wire
